// File: rtl/nand_pin_params.svh
`ifndef NAND_PIN_PARAMS_SVH
`define NAND_PIN_PARAMS_SVH

// column address width and last byte offset that exists in a page
`define COL_ADDR_W 12
`define COL_LAST_VALID 12'h87f
// row address bit that picks the plane
`define PLANE_ROW_BIT 6
// bits of a frame that are captured: one command byte and three address bytes
`define FRAME_BITS 6'h20
`define FRAME_CNT_W 6
`define CMD_BITS 6'h08
// reset values of the lock bits
`define PROTECT_RESET 4'hf
`define TOP_BOTTOM_RESET 1'h0

`endif

// File: rtl/nand_pin_pkg.sv
package nand_pin_pkg;

    // power state reported to the rest of the chip
    typedef enum logic [1:0] {
        PWR_STANDBY = 2'b00,
        PWR_ACTIVE  = 2'b01,
        PWR_BUSY    = 2'b10
    } power_e;

endpackage

// File: rtl/serial_nand_pin_interface.sv
// Behaviour
// - only column offsets 0..2175 are valid
// - one row address bit selects plane
// - chip select low means active power
// - deselected: serial output is high impedance
// - no command before first chip-select fall
// - standby when deselected and no long operation runs
// - frames are registered at chip-select rise
// - input sampled on rising serial clock
// - output changes only after falling clock
// - write protect blocks lock bit writes only when the disable setting is on
// - write-protect pin is input when deselected
// - pause feature off unless variant enables
// - pause suspends without deselecting device
// - paused: output released, clock/input ignored
// - pause entry timing versus clock level
// - pause exit timing versus clock level
// - works in clock modes 0 and 3
// - deselected: lines 0,1,2,3 all released, none driven
`include "nand_pin_params.svh"

module serial_nand_pin_interface
    import nand_pin_pkg::*;
#(
    parameter bit HOLD_ENABLE = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic hold_n_in,
    input wire logic io0_in,
    output logic io0_out,
    output logic io0_oe_out,
    input wire logic io1_in,
    output logic io1_out,
    output logic io1_oe_out,
    input wire logic io2_in,
    output logic io2_out,
    output logic io2_oe_out,
    input wire logic io3_in,
    output logic io3_out,
    output logic io3_oe_out,
    input wire logic [7:0] tx_byte_in,
    input wire logic op_in_progress_in,
    input wire logic lock_write_req_in,
    input wire logic [3:0] lock_write_range_in,
    input wire logic lock_write_top_bottom_in,
    input wire logic lock_bit_write_disable_in,
    output logic frame_valid_out,
    output logic [7:0] frame_cmd_out,
    output logic [23:0] frame_addr_out,
    output logic [5:0] frame_bits_out,
    output logic [`COL_ADDR_W-1:0] column_addr_out,
    output logic column_valid_out,
    output logic plane_select_out,
    output logic [1:0] power_state_out,
    output logic [3:0] protect_range_bits_out,
    output logic top_bottom_select_out,
    output logic lock_write_done_out,
    output logic lock_write_rejected_out
);

    // ************************************************************
    // link domain: serial clock side
    // ************************************************************

    logic link_rst;
    logic hold_rst;
    logic shift_en;
    logic [`FRAME_CNT_W-1:0] bit_cnt_q;
    logic [`FRAME_CNT_W-1:0] cap_cnt_q;
    logic [31:0] cap_q;
    logic [2:0] tx_idx_q;
    logic io1_out_q;
    logic io1_oe_q;
    logic [7:0] tx_hold_q;

    // deselect clears the link counters and output; sck is idle then, so no edge is missed
    assign link_rst = cs_n_in | rst_in;
    // pause only exists on variants that enable it
    assign hold_rst = HOLD_ENABLE & ~hold_n_in;
    // a low pause pin at a clock edge freezes the shifter
    assign shift_en = ~(HOLD_ENABLE & ~hold_n_in);

    // bit position within the frame; frozen, not cleared, while paused
    always_ff @(posedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_q <= '0;
        end else if (shift_en && bit_cnt_q != `FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    // capture survives deselect so the core side can read it after the frame
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            cap_q <= '0;
            cap_cnt_q <= '0;
        end else if (shift_en && bit_cnt_q != `FRAME_BITS) begin
            cap_q <= {cap_q[30:0], io0_in};
            cap_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    // output bit index; resumes where it stopped after a pause
    always_ff @(negedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            tx_idx_q <= '0;
            io1_out_q <= 1'b0;
        end else if (shift_en && bit_cnt_q >= `CMD_BITS) begin
            io1_out_q <= tx_hold_q[3'h7 - tx_idx_q];
            tx_idx_q <= tx_idx_q + 3'h1;
        end
    end

    // drive starts at a falling edge after the command; released at once
    // on deselect or pause entry, retaken at the next falling edge
    always_ff @(negedge sck_in or posedge link_rst or posedge hold_rst) begin
        if (link_rst) begin
            io1_oe_q <= 1'b0;
        end else if (hold_rst) begin
            io1_oe_q <= 1'b0;
        end else begin
            io1_oe_q <= (bit_cnt_q >= `CMD_BITS);
        end
    end

    assign io1_out = io1_out_q;
    assign io1_oe_out = io1_oe_q;

    // ************************************************************
    // core domain: pin synchronisers and static lines
    // ************************************************************

    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic wp_s1_q;
    logic wp_s2_q;
    logic cs_fall;
    logic cs_rise;

    // two flops before use; the third flop feeds the edge detector and the reply byte load
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_n_in;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= io2_in;
            wp_s2_q <= wp_s1_q;
        end
    end

    assign cs_fall = ~cs_s2_q & cs_s3_q;
    assign cs_rise = cs_s2_q & ~cs_s3_q;

    // lines 0, 2 and 3 are never driven here: no multi-line transfers,
    // so write protect and pause stay inputs at all times
    logic io_idle_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_idle_q <= 1'b0;
        end else begin
            io_idle_q <= 1'b0;
        end
    end

    assign io0_out = io_idle_q;
    assign io0_oe_out = io_idle_q;
    assign io2_out = io_idle_q;
    assign io2_oe_out = io_idle_q;
    assign io3_out = io_idle_q;
    assign io3_oe_out = io_idle_q;

    // reply byte only changes while deselected, so it is steady for the
    // whole frame that the link side reads it in
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_hold_q <= '0;
        end else if (cs_s2_q && cs_s3_q) begin
            tx_hold_q <= tx_byte_in;
        end
    end

    // ************************************************************
    // core domain: frame registration and address decode
    // ************************************************************

    function automatic logic col_in_range(input logic [`COL_ADDR_W-1:0] col);
        col_in_range = (col <= `COL_LAST_VALID);
    endfunction

    logic frame_open_q;
    logic frame_valid_q;
    logic [31:0] frame_q;
    logic [5:0] frame_bits_q;
    logic [31:0] aligned;

    // left-align so the command byte always sits at the top
    assign aligned = cap_q << (`FRAME_BITS - cap_cnt_q);

    // a frame only counts if its opening fall was seen after reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_open_q <= 1'b0;
        end else if (cs_fall) begin
            frame_open_q <= 1'b1;
        end else if (cs_rise) begin
            frame_open_q <= 1'b0;
        end
    end

    // the link clock is idle once select is high, so the capture is stable
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_valid_q <= 1'b0;
            frame_q <= '0;
            frame_bits_q <= '0;
        end else begin
            frame_valid_q <= cs_rise & frame_open_q;
            if (cs_rise && frame_open_q) begin
                frame_q <= aligned;
                frame_bits_q <= cap_cnt_q;
            end
        end
    end

    assign frame_valid_out = frame_valid_q;
    assign frame_cmd_out = frame_q[31:24];
    assign frame_addr_out = frame_q[23:0];
    assign frame_bits_out = frame_bits_q;

    // column from address bytes one and two, plane from the row address
    logic [`COL_ADDR_W-1:0] col_q;
    logic col_ok_q;
    logic plane_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            col_q <= '0;
            col_ok_q <= 1'b0;
            plane_q <= 1'b0;
        end else if (cs_rise && frame_open_q) begin
            col_q <= aligned[8 +: `COL_ADDR_W];
            col_ok_q <= col_in_range(aligned[8 +: `COL_ADDR_W]);
            plane_q <= aligned[`PLANE_ROW_BIT];
        end
    end

    assign column_addr_out = col_q;
    assign column_valid_out = col_ok_q;
    assign plane_select_out = plane_q;

    // ************************************************************
    // core domain: power state and lock bits
    // ************************************************************

    power_e pwr_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pwr_q <= PWR_STANDBY;
        end else begin
            case (pwr_q)
                PWR_STANDBY, PWR_ACTIVE, PWR_BUSY: begin
                    if (!cs_s2_q) begin
                        pwr_q <= PWR_ACTIVE;
                    end else if (op_in_progress_in) begin
                        pwr_q <= PWR_BUSY;
                    end else begin
                        pwr_q <= PWR_STANDBY;
                    end
                end
                default: begin
                    pwr_q <= PWR_STANDBY;
                end
            endcase
        end
    end

    assign power_state_out = pwr_q;

    // write protect low plus the disable setting freezes the lock bits
    logic [3:0] prot_q;
    logic tb_q;
    logic lock_done_q;
    logic lock_rej_q;
    logic lock_block;
    assign lock_block = ~wp_s2_q & lock_bit_write_disable_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prot_q <= `PROTECT_RESET;
            tb_q <= `TOP_BOTTOM_RESET;
            lock_done_q <= 1'b0;
            lock_rej_q <= 1'b0;
        end else begin
            lock_done_q <= lock_write_req_in & ~lock_block;
            lock_rej_q <= lock_write_req_in & lock_block;
            if (lock_write_req_in && !lock_block) begin
                prot_q <= lock_write_range_in;
                tb_q <= lock_write_top_bottom_in;
            end
        end
    end

    assign protect_range_bits_out = prot_q;
    assign top_bottom_select_out = tb_q;
    assign lock_write_done_out = lock_done_q;
    assign lock_write_rejected_out = lock_rej_q;

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_rise_open;
        cs_rise && frame_open_q;
    endsequence

    AST_FRAME_AT_RISE: assert property (
        s_rise_open |=> frame_valid_out ##1 !frame_valid_out)
        else $error("frame not registered at select rise");
    AST_NO_FRAME_MID: assert property (
        frame_valid_out |-> $past(cs_rise))
        else $error("frame registered without select rise");
    AST_ARMED_FIRST: assert property (
        cs_rise && !frame_open_q |=> !frame_valid_out)
        else $error("frame accepted before a select fall");
    AST_COL_RANGE: assert property (
        frame_valid_out |-> column_valid_out == (column_addr_out <= 12'h87f))
        else $error("column range flag wrong");
    AST_PLANE: assert property (
        frame_valid_out |-> plane_select_out == frame_addr_out[6])
        else $error("plane select not from row bit");
    AST_ACTIVE: assert property (
        !cs_s2_q |=> power_state_out == PWR_ACTIVE)
        else $error("not active while selected");
    AST_STANDBY: assert property (
        cs_s2_q && !op_in_progress_in |=> power_state_out == PWR_STANDBY)
        else $error("not standby when idle");
    AST_LOCK_REJECT: assert property (
        lock_write_req_in && lock_block |=> lock_write_rejected_out
            && $stable(protect_range_bits_out) && $stable(top_bottom_select_out))
        else $error("protected lock bits changed");
    AST_OUT_HIGHZ: assert property (
        cs_s2_q && cs_s3_q |-> !io1_oe_out)
        else $error("serial output driven while deselected");
    AST_WP_INPUT: assert property (
        cs_s2_q |-> !io2_oe_out)
        else $error("write protect pin driven");

endmodule

// File: verif/spi_host.sv
module spi_host (
    output logic sck_out,
    output logic cs_n_out,
    output logic hold_n_out,
    output logic io0_out,
    input wire logic io1_in,
    input wire logic io1_oe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // host side model
    // ****************
    logic [7:0] rx_byte;
    logic oe_in_pause;
    // idle; pause pin rests high as a pull-up would hold it
    // no four-line reads are issued, so wp and pause stay plain inputs
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        hold_n_out = 1'b1;
        io0_out = 1'b0;
        rx_byte = 8'h00;
        oe_in_pause = 1'b0;
    end
    // one frame msb first at 30 ns per bit; pause before bit pause_at
    task automatic frame(input logic [39:0] d, input int n, input bit m3, input int pause_at);
        int i;
        sck_out = m3; // idle level never moves while deselected
        #15;
        cs_n_out = 1'b0;
        #15; // clock starts only once selected
        for (i = 0; i < n; i++) begin
            sck_out = 1'b0;
            io0_out = d[39-i];
            if (i == pause_at) begin
                #5;
                hold_n_out = 1'b0; // pause only while selected, clock low
                repeat (3) begin
                    #15 sck_out = 1'b1;
                    io0_out = ~io0_out;
                    #15 sck_out = 1'b0;
                    oe_in_pause = oe_in_pause | io1_oe_in;
                end
                io0_out = d[39-i];
                #5 hold_n_out = 1'b1;
            end
            #15;
            sck_out = 1'b1;
            if (i >= 8 && i < 16) rx_byte = {rx_byte[6:0], io1_in};
            #15;
        end
        sck_out = m3;
        #15;
        cs_n_out = 1'b1; // raised only after the whole sequence
        io0_out = ~io0_out; // released line must not keep a stale value
    endtask
endmodule

// File: verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import nand_pin_pkg::*;
    // ****************
    // stimulus, checks
    // ****************
    logic clk_in = 0, rst_in = 1, io2_in = 1, op_in_progress_in = 0, lock_write_req_in = 0;
    logic lock_write_top_bottom_in = 0, lock_bit_write_disable_in = 0;
    logic [3:0] lock_write_range_in = 0, ep;
    logic [7:0] tx_byte_in = 0;
    logic sck_in, cs_n_in, hold_n_in, io0_in, io1_out, io1_oe_out, io0_oe_out, io2_oe_out;
    logic io3_oe_out, frame_valid_out, column_valid_out, plane_select_out, top_bottom_select_out;
    logic lock_write_done_out, lock_write_rejected_out, et, rej, io0_out, io2_out, io3_out;
    logic [7:0] frame_cmd_out;
    logic [23:0] frame_addr_out;
    logic [5:0] frame_bits_out;
    logic [11:0] column_addr_out;
    logic [11:0] cols [4] = '{12'h87f, 12'h880, 12'h000, 12'hfff};
    logic [1:0] power_state_out;
    logic [3:0] protect_range_bits_out;
    logic [31:0] r;
    int seed = 36186, n_errors = 0, n_tests = 0, i, k, n;
    always #5 clk_in = ~clk_in;
    serial_nand_pin_interface #(.HOLD_ENABLE(1'b1)) dut (.clk_in, .rst_in, .sck_in, .cs_n_in,
        .hold_n_in, .io0_in, .io0_out, .io0_oe_out, .io1_in(1'b0), .io1_out, .io1_oe_out,
        .io2_in, .io2_out, .io2_oe_out, .io3_in(1'b0), .io3_out, .io3_oe_out, .tx_byte_in,
        .op_in_progress_in, .lock_write_req_in, .lock_write_range_in, .lock_write_top_bottom_in,
        .lock_bit_write_disable_in, .frame_valid_out, .frame_cmd_out, .frame_addr_out,
        .frame_bits_out, .column_addr_out, .column_valid_out, .plane_select_out, .power_state_out,
        .protect_range_bits_out, .top_bottom_select_out, .lock_write_done_out,
        .lock_write_rejected_out);
    spi_host host (.sck_out(sck_in), .cs_n_out(cs_n_in), .hold_n_out(hold_n_in),
        .io0_out(io0_in), .io1_in(io1_oe_out ? io1_out : ~io1_out), .io1_oe_in(io1_oe_out));
    task automatic stop_test;
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // expected capture: first bits left aligned, zeros below, 32 at most
    task automatic run_frame(input logic [39:0] d, input int n, input bit m3, input int p);
        logic [31:0] w;
        int ne;
        ne = (n > 32) ? 32 : n;
        w = d[39:8] & ~(32'hffffffff >> ne);
        r = $random(seed);
        op_in_progress_in <= r[0];
        tx_byte_in <= r[15:8];
        repeat (3) @(posedge clk_in); // reply byte settles while deselected
        fork
            host.frame(d, n, m3, p);
            begin
                #200;
                check(power_state_out, PWR_ACTIVE);
            end
        join
        k = 0;
        while (frame_valid_out !== 1'b1 && k < 20) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        check(k < 20, 1'b1);
        check(frame_cmd_out, w[31:24]);
        check(frame_addr_out, w[23:0]);
        check(frame_bits_out, ne);
        check(column_addr_out, w[19:8]);
        check(column_valid_out, w[19:8] <= 12'h87f);
        check(plane_select_out, w[6]);
        check(io1_oe_out, 1'b0);
        if (n >= 16) check(host.rx_byte, r[15:8]);
        @(posedge clk_in);
        #1;
        check(power_state_out, r[0] ? PWR_BUSY : PWR_STANDBY);
    endtask
    // hang guard, far beyond the roughly sixteen microseconds needed
    initial begin
        #300000;
        n_errors++;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (5) @(posedge clk_in); // select must be seen high before any frame
        #1;
        check({protect_range_bits_out, top_bottom_select_out}, 5'h1e);
        check({io0_oe_out, io2_oe_out, io3_oe_out}, 3'h0);
        check({io0_out, io2_out, io3_out}, 3'h0);
        ep = 4'hf;
        et = 1'b0;
        // lock writes, first four sweep every protect and disable pairing
        for (i = 0; i < 12; i++) begin
            r = $random(seed);
            if (i < 4) r[1:0] = i[1:0];
            io2_in <= r[0];
            lock_bit_write_disable_in <= r[1];
            repeat (3) @(posedge clk_in);
            lock_write_range_in <= r[5:2];
            lock_write_top_bottom_in <= r[6];
            lock_write_req_in <= 1'b1;
            @(posedge clk_in);
            lock_write_req_in <= 1'b0;
            #1;
            rej = !r[0] && r[1];
            if (!rej) {ep, et} = {r[5:2], r[6]};
            check({lock_write_done_out, lock_write_rejected_out}, {!rej, rej});
            check({protect_range_bits_out, top_bottom_select_out}, {ep, et});
        end
        // frames: mode 0 first, then a mid-run reset moves the idle clock to mode 3
        for (i = 0; i < 14; i++) begin
            if (i == 7) begin
                rst_in <= 1'b1;
                repeat (3) @(posedge clk_in);
                host.sck_out = 1'b1;
                rst_in <= 1'b0;
                repeat (5) @(posedge clk_in);
                #1;
                check(protect_range_bits_out, 4'hf);
            end
            r = $random(seed);
            n = 8 + r[5:0] % 33;
            r = $random(seed);
            k = i % 7;
            if (k < 4) r[19:8] = cols[k];
            if (k < 4 || k == 5) n = 32;
            if (k == 4) n = 40;
            run_frame({r, r[15:8] ^ 8'h5a}, n, i >= 7, (k == 5) ? 20 : 99);
        end
        check(host.oe_in_pause, 1'b0);
        stop_test;
    end
endmodule
